// file: rtl/accm_top.v
// converter clock/mode configuration with apb registers and conversion sequencer
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`include "accm_regs.vh"
module accm_top (
    input  wire        MCLK_I,
    input  wire        SRST_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    input  wire        HW_TRIGGER_I,
    input  wire        FIFO_ACTIVE_I,
    input  wire [3:0]  FIFO_DEPTH_I,
    input  wire        ALT_TICK_I,
    input  wire        ASYNC_TICK_I,
    output reg         CONV_BUSY_O,
    output reg         SAMPLE_O,
    output reg         CONV_DONE_O,
    output reg         LOW_POWER_O,
    output reg  [1:0]  RES_SEL_O
);
    localparam ST_IDLE   = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_CONV   = 3'b100;

    reg  [7:0]  conv_cfg_q;
    reg         multi_trig_q;
    reg  [7:0]  act_cfg_q;      // snapshot used by the running conversion
    reg  [2:0]  state_q;
    reg  [7:0]  cnt_q;
    reg  [3:0]  left_q;         // conversions still owed to this trigger after the running one
    reg         trig_q;
    reg  [31:0] rdata_d;
    reg         hit_d;
    wire        tick;
    wire        setup  = PSEL_I && !PENABLE_I;
    wire        wr_acc = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    wire        trig_rise = HW_TRIGGER_I && !trig_q;
    wire [7:0]  smp_len = act_cfg_q[`ACCM_BIT_LONG_SMP] ? `ACCM_LONG_SMP_CYC
                                                         : `ACCM_SHORT_SMP_CYC;
    wire [7:0]  bit_len = (act_cfg_q[`ACCM_BIT_RES_HI:`ACCM_BIT_RES_LO] == `ACCM_RES_8)  ? 8'h08 :
                          (act_cfg_q[`ACCM_BIT_RES_HI:`ACCM_BIT_RES_LO] == `ACCM_RES_10) ? 8'h0a :
                                                                                     8'h0c;

    // conversion clock derived from selected source and divider of the active setup
    accm_clkdiv u_div (
        .clk_i        (MCLK_I),
        .rst_i        (SRST_I),
        .run_i        (state_q != ST_IDLE),
        .src_sel_i    (act_cfg_q[`ACCM_BIT_SRC_HI:`ACCM_BIT_SRC_LO]),
        .div_sel_i    (act_cfg_q[`ACCM_BIT_DIV_HI:`ACCM_BIT_DIV_LO]),
        .alt_tick_i   (ALT_TICK_I),
        .async_tick_i (ASYNC_TICK_I),
        .tick_o       (tick)
    );

    // read mux; reserved upper bits come back as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        case (PADDR_I)
            `ACCM_OFS_CONV_CFG:  rdata_d = {24'h00_0000, conv_cfg_q};
            `ACCM_OFS_FIFO_TRIG: rdata_d = {23'h00_0000, multi_trig_q, 8'h00};
            `ACCM_OFS_STATUS:    rdata_d = {24'h00_0000, left_q, 1'b0, state_q};
            default:             hit_d   = 1'b0;
        endcase
    end

    // apb slave: no wait states, ready raised in the setup cycle's following edge
    always @(posedge MCLK_I) begin
        if (SRST_I) begin
            PREADY_O     <= 1'b0;
            PSLVERR_O    <= 1'b0;
            PRDATA_O     <= 32'h0000_0000;
            conv_cfg_q   <= `ACCM_CONV_CFG_RST;
            multi_trig_q <= 1'b0;
        end else begin
            PREADY_O  <= setup;
            PSLVERR_O <= setup && !hit_d;
            PRDATA_O  <= (setup && !PWRITE_I) ? rdata_d : 32'h0000_0000;
            if (wr_acc && PADDR_I == `ACCM_OFS_CONV_CFG)
                conv_cfg_q <= PWDATA_I[7:0];
            if (wr_acc && PADDR_I == `ACCM_OFS_FIFO_TRIG)
                multi_trig_q <= PWDATA_I[`ACCM_BIT_MULTI_TRIG];
        end
    end

    // sequencer: trigger edge starts one conversion, or a fifo-depth burst
    always @(posedge MCLK_I) begin
        if (SRST_I) begin
            state_q     <= ST_IDLE;
            cnt_q       <= 8'h00;
            left_q      <= 4'h0;
            trig_q      <= 1'b0;
            act_cfg_q   <= `ACCM_CONV_CFG_RST;
            CONV_BUSY_O <= 1'b0;
            SAMPLE_O    <= 1'b0;
            CONV_DONE_O <= 1'b0;
            LOW_POWER_O <= 1'b0;
            RES_SEL_O   <= 2'h0;
        end else begin
            trig_q      <= HW_TRIGGER_I;
            CONV_DONE_O <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (trig_rise) begin
                        act_cfg_q <= conv_cfg_q;
                        cnt_q     <= 8'h00;
                        state_q   <= ST_SAMPLE;
                        if (multi_trig_q && FIFO_ACTIVE_I && FIFO_DEPTH_I != 4'h0)
                            left_q <= FIFO_DEPTH_I - 4'h1;
                        else
                            left_q <= 4'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (cnt_q + 8'h01 >= smp_len) begin
                            cnt_q   <= 8'h00;
                            state_q <= ST_CONV;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        if (cnt_q + 8'h01 >= bit_len) begin
                            cnt_q       <= 8'h00;
                            CONV_DONE_O <= 1'b1;
                            if (left_q != 4'h0) begin
                                left_q    <= left_q - 4'h1;
                                act_cfg_q <= conv_cfg_q;
                                state_q   <= ST_SAMPLE;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            CONV_BUSY_O <= (state_q != ST_IDLE);
            SAMPLE_O    <= (state_q == ST_SAMPLE);
            LOW_POWER_O <= act_cfg_q[`ACCM_BIT_LOW_POWER];
            RES_SEL_O   <= act_cfg_q[`ACCM_BIT_RES_HI:`ACCM_BIT_RES_LO];
        end
    end
endmodule

// file: rtl/accm_regs.vh
// register map, field positions and reset values of the converter clock and mode block
//
// Summary of operation
// - conversion_config bits 31-8 read zero
// - bit 7 picks low power over speed
// - bits 6-5 divide source by 1,2,4,8
// - bit 4 picks long sample time
// - bits 3-2 pick 8, 10, 12 bit width
// - bits 1-0 pick divider source clock
// - fifo_trigger_config bits 31-9 read zero
// - bit 8 enables multi conversion per trigger
// - trigger starts one, or several in fifo mode with bit 8 set
`ifndef ACCM_REGS_VH
`define ACCM_REGS_VH
`define ACCM_OFS_CONV_CFG    12'h008
`define ACCM_OFS_FIFO_TRIG   12'h00c
`define ACCM_OFS_STATUS      12'h010
`define ACCM_CONV_CFG_MASK   32'h0000_00ff
`define ACCM_FIFO_TRIG_MASK  32'h0000_0100
`define ACCM_CONV_CFG_RST    8'h00
`define ACCM_BIT_LOW_POWER   7
`define ACCM_BIT_DIV_HI      6
`define ACCM_BIT_DIV_LO      5
`define ACCM_BIT_LONG_SMP    4
`define ACCM_BIT_RES_HI      3
`define ACCM_BIT_RES_LO      2
`define ACCM_BIT_SRC_HI      1
`define ACCM_BIT_SRC_LO      0
`define ACCM_BIT_MULTI_TRIG  8
`define ACCM_SRC_BUS         2'h0
`define ACCM_SRC_BUS_HALF    2'h1
`define ACCM_SRC_ALT         2'h2
`define ACCM_SRC_ASYNC       2'h3
`define ACCM_RES_8           2'h0
`define ACCM_RES_10          2'h1
`define ACCM_RES_12          2'h2
`define ACCM_SHORT_SMP_CYC   8'h04
`define ACCM_LONG_SMP_CYC    8'h14
`endif

// file: rtl/accm_clkdiv.v
// conversion clock tick generator: source select and power-of-two divide
`timescale 1ns/100ps
`include "accm_regs.vh"
module accm_clkdiv (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       run_i,
    input  wire [1:0] src_sel_i,
    input  wire [1:0] div_sel_i,
    input  wire       alt_tick_i,
    input  wire       async_tick_i,
    output reg        tick_o
);
    reg        half_q;
    reg  [2:0] cnt_q;
    reg        src_tick;
    wire [2:0] limit = (3'h1 << div_sel_i) - 3'h1;

    // pick the source pulse; the async clock arrives as a pre-synchronised tick
    always @* begin
        case (src_sel_i)
            `ACCM_SRC_BUS:      src_tick = 1'b1;
            `ACCM_SRC_BUS_HALF: src_tick = half_q;
            `ACCM_SRC_ALT:      src_tick = alt_tick_i;
            default:            src_tick = async_tick_i;
        endcase
    end

    // divide by 1,2,4,8; counter restarts when idle so the first conversion of each trigger starts aligned
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            half_q <= 1'b0;
            cnt_q  <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            half_q <= ~half_q;
            tick_o <= 1'b0;
            if (src_tick) begin
                if (cnt_q >= limit) begin
                    cnt_q  <= 3'h0;
                    tick_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    end
endmodule

// file: verif/accm_chk_assertions.sv
// assertion checker for the converter clock and mode block
`timescale 1ns/100ps
module accm_chk (
    input wire        MCLK_I,
    input wire        SRST_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    input wire        HW_TRIGGER_I,
    input wire        CONV_BUSY_O,
    input wire        CONV_DONE_O,
    input wire        LOW_POWER_O,
    input wire [1:0]  RES_SEL_O
);
    reg  [7:0] cfg_q;
    reg        mt_q;
    wire       wr_x = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire       rd_x = PREADY_O && !PWRITE_I;
    wire       map_x = PADDR_I == 12'h008 || PADDR_I == 12'h00c || PADDR_I == 12'h010;
    // shadow of what software wrote; reserved bits never stored
    always @(posedge MCLK_I) begin
        if (SRST_I) begin
            cfg_q <= 8'h00;
            mt_q  <= 1'b0;
        end else if (wr_x && PADDR_I == 12'h008) cfg_q <= PWDATA_I[7:0];
        else if (wr_x && PADDR_I == 12'h00c) mt_q <= PWDATA_I[8];
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);
    AST_RDY_LAT: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("ready late");
    AST_RDY_ONE: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready too long");
    AST_CONV_RD: assert property (rd_x && PADDR_I == 12'h008 |-> PRDATA_O == {24'h0, cfg_q})
        else $error("config read wrong");
    AST_FIFO_RD: assert property (rd_x && PADDR_I == 12'h00c |-> PRDATA_O == {23'h0, mt_q, 8'h0})
        else $error("trigger read wrong");
    AST_MAP: assert property (PREADY_O |-> PSLVERR_O == !map_x)
        else $error("slverr wrong");
    AST_LP: assert property (CONV_DONE_O |-> LOW_POWER_O == cfg_q[7])
        else $error("power mode wrong");
    AST_RES: assert property (CONV_DONE_O && cfg_q[3:2] != 2'h3 |-> RES_SEL_O == cfg_q[3:2])
        else $error("resolution wrong");
    AST_DONE_ONE: assert property (CONV_DONE_O |=> !CONV_DONE_O)
        else $error("done not a pulse");
    AST_START: assert property ($rose(HW_TRIGGER_I) && !CONV_BUSY_O |-> ##[1:3] CONV_BUSY_O)
        else $error("trigger not taken");
    cover property (rd_x && PADDR_I == 12'h008);
    cover property (PREADY_O && PSLVERR_O);
    cover property (CONV_DONE_O && mt_q);
endmodule
bind accm_top accm_chk accm_chk_i (.*);

// file: verif/test_adc_clock_mode_config.sv
// self-checking bench for the converter clock and mode block
`timescale 1ns/100ps
`include "accm_regs.vh"
module test_adc_clock_mode_config;
    reg        MCLK_I = 1'b0, SRST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    reg [11:0] PADDR_I = 12'h000;
    reg [31:0] PWDATA_I = 32'h0;
    reg        HW_TRIGGER_I = 1'b0, FIFO_ACTIVE_I = 1'b0, ALT_TICK_I = 1'b0, ASYNC_TICK_I = 1'b0;
    reg [3:0]  FIFO_DEPTH_I = 4'h0;
    wire [31:0] PRDATA_O;
    wire       PREADY_O, PSLVERR_O, CONV_BUSY_O, SAMPLE_O, CONV_DONE_O, LOW_POWER_O;
    wire [1:0] RES_SEL_O;
    reg [7:0]  w;
    integer    fails = 0, n_tests = 0, i, c, p, x, s;
    accm_top accm_top_i (.*);
    always #25 MCLK_I = ~MCLK_I;
    // free-running stand-ins for the alternate and async clock edges
    always @(posedge MCLK_I) {ALT_TICK_I, ASYNC_TICK_I} <= 2'($urandom);
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("Error %0s: expected %h, seen %h", nm, exp, seen);
            end
        end
    endtask
    // one apb transfer; request held until pready is sampled high, answer taken at that edge
    // no fixed wait is assumed: only the watchdog ends a slave that never answers
    task apb(input wr, input [11:0] a, input [31:0] d, input [31:0] xq, input xe);
        begin
            @(posedge MCLK_I);
            PSEL_I <= 1'b1;
            PWRITE_I <= wr;
            PADDR_I <= a;
            PWDATA_I <= d;
            @(posedge MCLK_I);
            PENABLE_I <= 1'b1;
            @(posedge MCLK_I);
            while (PREADY_O !== 1'b1)
                @(posedge MCLK_I);
            if (!wr) chk("prdata", PRDATA_O, xq);
            chk("pslverr", 32'(PSLVERR_O), 32'(xe));
            PSEL_I <= 1'b0;
            PENABLE_I <= 1'b0;
        end
    endtask
    // one trigger pulse; counts done pulses, c keeps edges to the first, s sample cycles
    task trig(input integer nexp);
        integer k, nd;
        reg     sb;
        begin
            nd = 0;
            sb = 1'b0;
            c = 0;
            s = 0;
            @(posedge MCLK_I) HW_TRIGGER_I <= 1'b1;
            for (k = 1; k < 5000 && !(sb && CONV_BUSY_O === 1'b0); k = k + 1) begin
                @(posedge MCLK_I) HW_TRIGGER_I <= 1'b0;
                #1;
                if (nd == 0 && SAMPLE_O === 1'b1) s = s + 1;
                if (CONV_DONE_O === 1'b1) nd = nd + 1;
                if (nd == 1 && c == 0) c = k;
                if (CONV_BUSY_O === 1'b1) sb = 1'b1;
            end
            chk("bursts", nd, nexp);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d, mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        c = $urandom(32'he07ea908);
        repeat (3) @(posedge MCLK_I);
        SRST_I <= 1'b0;
        apb(0, 12'h008, 0, 0, 0);
        apb(0, 12'h00c, 0, 0, 0);
        apb(1, 12'h020, 32'hffffffff, 0, 1);
        apb(0, 12'h020, 0, 0, 1);
        apb(0, 12'h008, 0, 0, 0);
        $display("test reset_map done");
        // corners first (slowest divider, sample and width on bus source 00, then all-zero apart from source bits 01), then random; sources cycle
        for (i = 0; i < 10; i = i + 1) begin
            w = (i == 0) ? 8'hf8 : (i == 1) ? 8'h00 : 8'($urandom);
            w[1:0] = 2'(i);
            if (w[3:2] == 2'h3) w[3:2] = 2'h2;
            apb(1, 12'h008, ($urandom & 32'hffffff00) | w, 0, 0);
            apb(0, 12'h008, 0, {24'h0, w}, 0);
            trig(1);
            if (w[1:0] < 2'h2) begin
                p = (1 << w[6:5]) * (w[0] ? 2 : 1);
                x = (w[4] ? `ACCM_LONG_SMP_CYC : `ACCM_SHORT_SMP_CYC) * p;
                chk("smp_len", 32'(s >= x - p && s <= x + p + 2), 32'h1);
                x = x + (8 + 2 * w[3:2]) * p;
                chk("latency", 32'(c >= x - p && c <= x + p + 6), 32'h1);
            end
        end
        $display("test conv_cfg done");
        apb(1, 12'h00c, 32'hffffffff, 0, 0);
        apb(0, 12'h00c, 0, 32'h00000100, 0);
        FIFO_ACTIVE_I <= 1'b1;
        FIFO_DEPTH_I <= 4'h3;
        trig(3);
        FIFO_ACTIVE_I <= 1'b0;
        trig(1);
        apb(1, 12'h00c, 32'h0, 0, 0);
        FIFO_ACTIVE_I <= 1'b1;
        trig(1);
        $display("test multi done");
        // reset again mid-run: both registers must come back cleared
        apb(1, 12'h00c, 32'h00000100, 0, 0);
        SRST_I <= 1'b1;
        repeat (3) @(posedge MCLK_I);
        SRST_I <= 1'b0;
        apb(0, 12'h008, 0, 0, 0);
        apb(0, 12'h00c, 0, 0, 0);
        $display("test reset_again done");
        end_sim;
    end
    initial begin
        #2000000;
        fails = fails + 1;
        end_sim;
    end
endmodule
